// ---- core/bwu_map.svh ----
// offsets, reset values and fixed fields of the upper bridge window registers
`ifndef BWU_MAP_SVH
`define BWU_MAP_SVH
`define BWU_OFF_PF_BASE_HIGH 8'h28
`define BWU_OFF_PF_LIMIT_HIGH 8'h2c
`define BWU_OFF_IO_WINDOW_HIGH 8'h30
`define BWU_OFF_IO_BASE_HIGH 8'h30
`define BWU_OFF_IO_LIMIT_HIGH 8'h32
`define BWU_OFF_CAP_PTR 8'h34
`define BWU_OFF_IRQ_DWORD 8'h3c
`define BWU_OFF_IRQ_LINE 8'h3c
`define BWU_OFF_IRQ_PIN 8'h3d
`define BWU_RST_PF_BASE_HIGH 32'h0000_0000
`define BWU_RST_PF_LIMIT_HIGH 32'h0000_0000
`define BWU_RST_IO_BASE_HIGH 16'h0000
`define BWU_RST_IO_LIMIT_HIGH 16'h0000
`define BWU_RST_IRQ_LINE 8'hff
`define BWU_CAP_PTR_VALUE 8'h50
`define BWU_IRQ_PIN_VALUE 8'h00
`define BWU_LOW_BASE_FILL 20'h00000
`define BWU_LOW_LIMIT_FILL 20'hfffff
`define BWU_INTX_IDLE 4'hf
`endif

// ---- core/bwu_pkg.sv ----
// types for the upper bridge window register bank
package bwu_pkg;
  typedef struct packed {
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
    logic [7:0] irq_line;
    logic [31:0] rdata;
    logic ack;
    logic [63:0] pf_base_a;
    logic [63:0] pf_limit_a;
    logic [31:0] io_base_a;
    logic [31:0] io_limit_a;
    logic io_fwd;
    logic io_fwd_vld;
    logic pf_fwd;
    logic pf_fwd_vld;
    logic [3:0] intx_m;
    logic [3:0] intx_s;
    logic [3:0] intx_o;
  } bwu_state_s;
endpackage

// ---- core/bwu_regs.sv ----
// upper window, capability pointer and interrupt registers of a bridge header
`timescale 1ns/1ps
`include "bwu_map.svh"

module bwu_regs
  import bwu_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // configuration access
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  // lower window fields from the neighbouring header registers
  input wire logic [11:0] prefetch_window_base_lo_in,
  input wire logic [11:0] prefetch_window_limit_lo_in,
  // window boundaries for the forwarding datapath
  output logic [63:0] prefetch_window_base_out,
  output logic [63:0] prefetch_window_limit_out,
  output logic [31:0] io_window_base_out,
  output logic [31:0] io_window_limit_out,
  // i/o forwarding decision
  input wire logic io_req_valid_in,
  input wire logic [31:0] io_req_addr_in,
  output logic io_fwd_valid_out,
  output logic io_fwd_out,
  // prefetchable memory forwarding decision
  input wire logic pf_req_valid_in,
  input wire logic [63:0] pf_req_addr_in,
  output logic pf_fwd_valid_out,
  output logic pf_fwd_out,
  // interrupt pass-through, active low pins
  input wire logic [3:0] sec_intx_n_in,
  output logic [3:0] pri_intx_n_out
);

  bwu_state_s st_q;
  bwu_state_s st_d;

  logic [7:0] dw_addr;
  logic [63:0] pf_base_c;
  logic [63:0] pf_limit_c;
  logic [31:0] io_base_c;
  logic [31:0] io_limit_c;
  logic [31:0] rd_word;
  logic io_hit;
  logic pf_hit;
  logic rd_take;
  logic wr_take;

  // byte-enable merge of one write into a stored value
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // one byte lane of a write; the lane lands only when its enable is set
  function automatic logic [7:0] merge_lane(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic en
  );
    logic [7:0] res;
    res = old_v;
    if (en)
    begin
      res = new_v;
    end
    return res;
  endfunction

  // two byte lanes of a write into a 16-bit half register
  // the io base and limit each own one half of their shared dword
  function automatic logic [15:0] merge_half(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] be
  );
    logic [15:0] res;
    res[7:0] = merge_lane(old_v[7:0], new_v[7:0], be[0]);
    res[15:8] = merge_lane(old_v[15:8], new_v[15:8], be[1]);
    return res;
  endfunction

  // inclusive window test; an inverted window (base above limit) matches nothing
  function automatic logic in_window(
    input logic [63:0] addr,
    input logic [63:0] lo,
    input logic [63:0] hi
  );
    return (addr >= lo) && (addr <= hi);
  endfunction

  // lowest address of a window: bits below the 1 MB granule are zeros
  function automatic logic [63:0] window_floor(input logic [43:0] upper);
    return {upper, `BWU_LOW_BASE_FILL};
  endfunction

  // highest address of a window: bits below the 1 MB granule are ones
  function automatic logic [63:0] window_ceiling(input logic [43:0] upper);
    return {upper, `BWU_LOW_LIMIT_FILL};
  endfunction

  // bits 1:0 are dropped: every access is a whole dword, lanes picked by the enables
  assign dw_addr = {cfg_addr_in[7:2], 2'b00};
  // a read and a write in the same cycle: the read is taken and the write is lost
  assign rd_take = cfg_rd_in;
  assign wr_take = cfg_wr_in && !cfg_rd_in;

  // window boundaries assembled from upper and lower parts
  always_comb
  begin
    pf_base_c = window_floor({st_q.pf_base_hi, prefetch_window_base_lo_in});
    pf_limit_c = window_ceiling({st_q.pf_limit_hi, prefetch_window_limit_lo_in});
    // only bits 15:4 carry address bits 31:20; bits 3:0 are stored and read back
    io_base_c = 32'(window_floor({32'h0000_0000, st_q.io_base_hi[15:4]}));
    io_limit_c = 32'(window_ceiling({32'h0000_0000, st_q.io_limit_hi[15:4]}));
  end

  // address tests use this cycle's registers, so a write counts from the next request on
  always_comb
  begin
    io_hit = in_window({32'h0000_0000, io_req_addr_in},
                       {32'h0000_0000, io_base_c},
                       {32'h0000_0000, io_limit_c});
    pf_hit = in_window(pf_req_addr_in, pf_base_c, pf_limit_c);
  end

  // read data for the addressed dword; holes and foreign lanes read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (dw_addr)
      `BWU_OFF_PF_BASE_HIGH:
      begin
        rd_word = st_q.pf_base_hi;
      end
      `BWU_OFF_PF_LIMIT_HIGH:
      begin
        rd_word = st_q.pf_limit_hi;
      end
      `BWU_OFF_IO_WINDOW_HIGH:
      begin
        rd_word = {st_q.io_limit_hi, st_q.io_base_hi};
      end
      `BWU_OFF_CAP_PTR:
      begin
        rd_word = {24'h000000, `BWU_CAP_PTR_VALUE};
      end
      `BWU_OFF_IRQ_DWORD:
      begin
        rd_word = {16'h0000, `BWU_IRQ_PIN_VALUE, st_q.irq_line};
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    // ack is a one-cycle pulse; read data stays until the next read
    st_d.ack = 1'b0;
    if (rd_take)
    begin
      st_d.rdata = rd_word;
      st_d.ack = 1'b1;
    end
    else if (wr_take)
    begin
      st_d.ack = 1'b1;
      // read-only bytes and unmapped dwords take the write with no effect
      case (dw_addr)
        `BWU_OFF_PF_BASE_HIGH:
        begin
          st_d.pf_base_hi = merge_bytes(st_q.pf_base_hi, cfg_wdata_in, cfg_be_in);
        end
        `BWU_OFF_PF_LIMIT_HIGH:
        begin
          st_d.pf_limit_hi = merge_bytes(st_q.pf_limit_hi, cfg_wdata_in, cfg_be_in);
        end
        `BWU_OFF_IO_WINDOW_HIGH:
        begin
          // the two halves of this dword are separate registers with their own lanes
          st_d.io_base_hi = merge_half(st_q.io_base_hi, cfg_wdata_in[15:0],
            cfg_be_in[1:0]);
          st_d.io_limit_hi = merge_half(st_q.io_limit_hi, cfg_wdata_in[31:16],
            cfg_be_in[3:2]);
        end
        `BWU_OFF_CAP_PTR:
        begin
          // the pointer byte is a constant and the other bytes read zero, so a write has nothing to land in
          st_d.irq_line = st_q.irq_line;
        end
        `BWU_OFF_IRQ_DWORD:
        begin
          // only lane 0 is writable; lane 1 holds the fixed pin value
          st_d.irq_line = merge_lane(st_q.irq_line, cfg_wdata_in[7:0],
            cfg_be_in[0]);
        end
        default:
        begin
          st_d.irq_line = st_q.irq_line;
        end
      endcase
    end
    // window outputs trail the registers by one cycle, like every other output
    st_d.pf_base_a = pf_base_c;
    st_d.pf_limit_a = pf_limit_c;
    st_d.io_base_a = io_base_c;
    st_d.io_limit_a = io_limit_c;
    // decisions follow the request by one cycle
    st_d.io_fwd_vld = io_req_valid_in;
    st_d.io_fwd = io_req_valid_in && io_hit;
    st_d.pf_fwd_vld = pf_req_valid_in;
    st_d.pf_fwd = pf_req_valid_in && pf_hit;
    // pins come from the secondary bus, so two flops before use
    st_d.intx_m = sec_intx_n_in;
    st_d.intx_s = st_q.intx_m;
    // a third flop drives the pin so the output comes straight from a register
    st_d.intx_o = st_q.intx_s;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_q.pf_base_hi <= `BWU_RST_PF_BASE_HIGH;
      st_q.pf_limit_hi <= `BWU_RST_PF_LIMIT_HIGH;
      st_q.io_base_hi <= `BWU_RST_IO_BASE_HIGH;
      st_q.io_limit_hi <= `BWU_RST_IO_LIMIT_HIGH;
      st_q.irq_line <= `BWU_RST_IRQ_LINE;
      st_q.rdata <= 32'h0000_0000;
      st_q.ack <= 1'b0;
      st_q.pf_base_a <= 64'h0000_0000_0000_0000;
      // limit outputs reset with their fill bits at ones, as the zeroed registers give
      st_q.pf_limit_a <= {44'h000_0000_0000, `BWU_LOW_LIMIT_FILL};
      st_q.io_base_a <= 32'h0000_0000;
      st_q.io_limit_a <= {12'h000, `BWU_LOW_LIMIT_FILL};
      st_q.io_fwd <= 1'b0;
      st_q.io_fwd_vld <= 1'b0;
      st_q.pf_fwd <= 1'b0;
      st_q.pf_fwd_vld <= 1'b0;
      st_q.intx_m <= `BWU_INTX_IDLE;
      st_q.intx_s <= `BWU_INTX_IDLE;
      st_q.intx_o <= `BWU_INTX_IDLE;
    end
    else if (clk_en_in)
    begin
      st_q <= st_d;
    end
  end

  // every output straight from the state register
  assign cfg_rdata_out = st_q.rdata;
  assign cfg_ack_out = st_q.ack;
  assign prefetch_window_base_out = st_q.pf_base_a;
  assign prefetch_window_limit_out = st_q.pf_limit_a;
  assign io_window_base_out = st_q.io_base_a;
  assign io_window_limit_out = st_q.io_limit_a;
  assign io_fwd_valid_out = st_q.io_fwd_vld;
  assign io_fwd_out = st_q.io_fwd;
  assign pf_fwd_valid_out = st_q.pf_fwd_vld;
  assign pf_fwd_out = st_q.pf_fwd;
  assign pri_intx_n_out = st_q.intx_o;

endmodule

// ---- verif/bwu_regs_properties.sv ----
// assertion checker for the upper bridge window register bank
`timescale 1ns/1ps
module bwu_regs_properties (
  // clock and reset
  input logic core_clk_in,
  input logic reset_n_in,
  // watched inputs
  input logic clk_en_in,
  input logic cfg_rd_in,
  input logic cfg_wr_in,
  input logic [7:0] cfg_addr_in,
  input logic io_req_valid_in,
  input logic [31:0] io_req_addr_in,
  input logic [3:0] sec_intx_n_in,
  // watched outputs
  input logic [31:0] cfg_rdata_out,
  input logic cfg_ack_out,
  input logic [31:0] io_window_base_out,
  input logic [31:0] io_window_limit_out,
  input logic io_fwd_valid_out,
  input logic io_fwd_out,
  input logic [3:0] pri_intx_n_out
);
  // window outputs lag a write by one cycle, so compares right after a write are skipped
  wire in_win = io_req_addr_in >= io_window_base_out && io_req_addr_in <= io_window_limit_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_ack; clk_en_in && (cfg_rd_in || cfg_wr_in) |=> cfg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_cap; clk_en_in && cfg_rd_in && cfg_addr_in == 8'h34 |=> cfg_rdata_out[7:0] == 8'h50;
  endproperty
  a_cap: assert property (p_cap) else $error("pointer not 50");
  property p_pin; clk_en_in && cfg_rd_in && cfg_addr_in == 8'h3c |=> cfg_rdata_out[15:8] == 8'h00;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not 00");
  property p_iob; clk_en_in |=> io_window_base_out[19:0] == 20'h00000; endproperty
  a_iob: assert property (p_iob) else $error("io base fill");
  property p_iol; clk_en_in |=> io_window_limit_out[19:0] == 20'hfffff; endproperty
  a_iol: assert property (p_iol) else $error("io limit fill");
  property p_fwdv; clk_en_in |=> io_fwd_valid_out == $past(io_req_valid_in); endproperty
  a_fwdv: assert property (p_fwdv) else $error("io valid lag");
  property p_fwd; clk_en_in && io_req_valid_in && !$past(cfg_wr_in) |=> io_fwd_out == $past(in_win);
  endproperty
  a_fwd: assert property (p_fwd) else $error("io forward wrong");
  property p_intx; (clk_en_in && $stable(sec_intx_n_in))[*5] |-> pri_intx_n_out == sec_intx_n_in;
  endproperty
  a_intx: assert property (p_intx) else $error("intx not passed");
endmodule
bind bwu_regs bwu_regs_properties u_chk (.*);

// ---- verif/bwu_regs_test.sv ----
// self-checking bench for the upper bridge window register bank
`timescale 1ns/1ps
module bwu_regs_test;
  logic core_clk_in = 0, reset_n_in = 0, clk_en_in = 1, cfg_rd_in = 0, cfg_wr_in = 0;
  logic io_req_valid_in = 0, pf_req_valid_in = 0, cfg_ack_out, io_fwd_valid_out, io_fwd_out;
  logic pf_fwd_valid_out, pf_fwd_out;
  logic [7:0] cfg_addr_in = '0;
  logic [3:0] cfg_be_in = '0, sec_intx_n_in = 4'hf, pri_intx_n_out;
  logic [11:0] prefetch_window_base_lo_in = 12'h001, prefetch_window_limit_lo_in = 12'h002;
  logic [31:0] cfg_wdata_in = '0, io_req_addr_in = '0, cfg_rdata_out, bh, d;
  logic [31:0] io_window_base_out, io_window_limit_out;
  logic [63:0] pf_req_addr_in = '0, prefetch_window_base_out, prefetch_window_limit_out;
  logic [32:0] n;
  logic [32:0] notes[$];
  logic [31:0] ioa[4] = '{32'h000f_ffff, 32'h0010_0000, 32'h002f_ffff, 32'h0030_0000};
  int error_cnt = 0, comparisons = 0, cycles = 0;
  bwu_regs dut_u (.*);
  always #5 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // request held through its sampling edge; no release between calls gives back to back
  task automatic go(input logic rd, input logic [7:0] a, input logic [31:0] wd, exp,
    input logic [3:0] be = 4'hf);
    cfg_rd_in = rd;
    cfg_wr_in = !rd;
    cfg_addr_in = a;
    cfg_be_in = be;
    cfg_wdata_in = wd;
    notes.push_back({rd, exp});
    @(posedge core_clk_in);
    #1;
  endtask
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      close_out();
    end
  end
  always @(posedge core_clk_in)
    if (cfg_ack_out === 1'h1)
    begin
      n = notes.pop_front();
      if (n[32])
        chk(cfg_rdata_out, n[31:0]);
    end
  initial
  begin
    void'($urandom(24304));
    repeat (2) @(posedge core_clk_in);
    #1;
    reset_n_in = 1;
    go(1, 8'h28, '0, '0);
    go(1, 8'h2c, '0, '0);
    go(1, 8'h30, '0, '0);
    go(1, 8'h34, '0, 32'h50);
    go(1, 8'h3c, '0, 32'hff);
    bh = $urandom() >> 1;
    d = $urandom();
    go(0, 8'h28, bh, '0);
    go(0, 8'h2c, bh + 1, '0);
    go(0, 8'h30, 32'h0020_0010, '0);
    go(0, 8'h34, d, '0);
    go(0, 8'h3c, d, '0);
    go(0, 8'h30, 32'h00ff_ffff, '0, 4'h8);
    go(0, 8'h3c, ~d, '0, 4'he);
    go(1, 8'h28, '0, bh);
    go(1, 8'h2c, '0, bh + 1);
    go(1, 8'h30, '0, 32'h0020_0010);
    go(1, 8'h34, '0, 32'h50);
    go(1, 8'h3c, '0, {24'h0, d[7:0]});
    cfg_rd_in = 0;
    cfg_wr_in = 0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(io_window_base_out, 32'h0010_0000);
    chk(io_window_limit_out, 32'h002f_ffff);
    chk(prefetch_window_base_out, {bh, 32'h0010_0000});
    chk(prefetch_window_limit_out, {bh + 1, 32'h002f_ffff});
    io_req_valid_in = 1;
    pf_req_valid_in = 1;
    foreach (ioa[i])
    begin
      io_req_addr_in = ioa[i];
      pf_req_addr_in = {bh + 1, ioa[i]};
      @(posedge core_clk_in);
      #1;
      chk(io_fwd_out, i == 1 || i == 2);
      chk(pf_fwd_out, i != 3);
      chk(io_fwd_valid_out, 1);
      chk(pf_fwd_valid_out, 1);
    end
    // clock enable low: pins and decisions must hold
    io_req_valid_in = 0;
    pf_req_valid_in = 0;
    clk_en_in = 0;
    d = $urandom();
    sec_intx_n_in = {1'b0, d[2:0]};
    repeat (4) @(posedge core_clk_in);
    #1;
    chk(pri_intx_n_out, 4'hf);
    chk(io_fwd_valid_out, 1);
    clk_en_in = 1;
    repeat (4) @(posedge core_clk_in);
    #1;
    chk(pri_intx_n_out, {1'b0, d[2:0]});
    chk(io_fwd_valid_out, 0);
    chk(pf_fwd_valid_out, 0);
    close_out();
  end
endmodule
